// *** src/rrx_pkg.sv ***
/*
  Constants, opcodes, register map and state codes for the return and
  reset instruction execution block.
  Assumes a four-phase instruction cycle made of four clk periods.
*/
// How it works
// RULE1 - The software reset opcode (one word) returns every register and flag to its reset value. The stack storage is not cleared, only the stack pointer.
// RULE2 - The return-from-irq opcode, select bit in bit 0, pops the stack into the PC in two cycles.
// RULE3 - Return-from-irq sets the high or low priority global interrupt enable and leaves the other one alone.
// RULE4 - With the select bit at 1 the shadow copies go back to accumulator, flags and bank select.
// RULE5 - With the select bit at 0 the accumulator, flags and bank select keep their values.
// RULE6 - Return-literal loads its 8-bit operand into the accumulator and leaves the flags alone.
// RULE7 - Return-literal pops the stack into the PC; one word, two instruction cycles.
// RULE8 - Neither return touches the upper or high PC latch registers.
// RULE9 - The second cycle of a return is a no-operation that discards the prefetched word.
// RULE10 - Each pop moves the stack pointer back by one so the previous entry becomes the top.
package rrx_pkg;

  // Instruction cycle phases
  localparam logic [1:0] RRX_Q1 = 2'h0;
  localparam logic [1:0] RRX_Q2 = 2'h1;
  localparam logic [1:0] RRX_Q4 = 2'h3;

  // Opcodes
  localparam logic [15:0] RRX_OP_SW_RESET  = 16'h00FF;
  localparam logic [15:0] RRX_OP_RETIRQ    = 16'h0010;
  localparam logic [15:0] RRX_RETIRQ_MASK  = 16'hFFFE;
  localparam logic [7:0]  RRX_OP_RETLIT_HI = 8'h0C;
  localparam int          RRX_SEL_BIT      = 0;

  // Flush length: one instruction cycle of clk periods
  localparam logic [2:0] RRX_FLUSH_CLKS = 3'h4;

  // APB register byte offsets
  localparam logic [7:0] RRX_A_CTRL    = 8'h00;
  localparam logic [7:0] RRX_A_CORE    = 8'h04;
  localparam logic [7:0] RRX_A_PC      = 8'h08;
  localparam logic [7:0] RRX_A_STACK   = 8'h0C;
  localparam logic [7:0] RRX_A_LATCH   = 8'h10;
  localparam logic [7:0] RRX_A_SHADOW  = 8'h14;

  // Field positions
  localparam int RRX_CTRL_EN    = 0;  // Execution enable
  localparam int RRX_CORE_STAT  = 8;  // Flags field start in CORE word
  localparam int RRX_CORE_BANK  = 16; // Bank field start in CORE word
  localparam int RRX_CORE_LOW_PRIO_GLOBAL_IRQ_EN  = 24;
  localparam int RRX_CORE_HIGH_PRIO_GLOBAL_IRQ_EN  = 25;
  localparam int RRX_CORE_ACT   = 26; // Block busy
  localparam int RRX_LATCH_UP   = 8;  // Upper latch field start
  localparam int RRX_STK_FULL   = 8;

  // Reset values
  localparam logic [31:0] RRX_CTRL_RST = 32'h0000_0001;

  typedef enum logic [1:0] {
    RRX_IDLE  = 2'b00,
    RRX_EXEC  = 2'b01,
    RRX_FLUSH = 2'b10
  } rrx_state_e;

endpackage

// *** src/rrx_exec.sv ***
/*
  Execution logic for the software reset, return-from-irq and
  return-literal instructions, with the return stack, accumulator,
  flags, bank select, shadow copies and global interrupt enables.
  Assumes the fetch stage presents instruction words at phase Q1 from
  logic on clk, and software reaches the registers over APB.
*/
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module rrx_exec
  import rrx_pkg::*;
#(
  parameter int PC_W        = 21,
  parameter int STACK_DEPTH = 31,
  parameter int PTR_W       = 5
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // Instruction from fetch and decode
  input  wire logic             instr_valid,
  input  wire logic [15:0]      instr_word,
  // Interrupt entry from the interrupt controller
  input  wire logic             irq_entry,
  input  wire logic             irq_level_high,
  input  wire logic [PC_W-1:0]  irq_ret_addr,
  // Execution results
  output logic [PC_W-1:0]       pc_o,
  output logic                  pc_load_o,
  output logic                  flush_o,
  output logic                  core_reset_o,
  output logic                  busy_o,
  output logic [7:0]            accumulator_o,
  output logic [7:0]            status_o,
  output logic [3:0]            bank_select_reg_o,
  output logic                  high_prio_global_irq_en_o,
  output logic                  low_prio_global_irq_en_o,
  // APB slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr
);

  rrx_state_e            state_q;
  logic [1:0]            phase_q;
  logic [15:0]           ir_q;
  logic [2:0]            flush_cnt_q;
  logic [PC_W-1:0]       pc_q, stack_top_entry;
  logic [7:0]            acc_q, status_q, acc_shadow_q, flag_shadow_q;
  logic [7:0]            pc_latch_high_q, pc_latch_upper_q;
  logic [3:0]            bsr_q, bank_shadow_q;
  logic [PC_W-1:0]       stack_q [STACK_DEPTH];
  logic [PTR_W-1:0]      sp_q;
  logic [31:0]           rd_mux;
  logic                  soft_rst_q, rst, pc_load_q, flush_q, busy_q;
  logic                  high_prio_global_irq_en_q, low_prio_global_irq_en_q, exec_en_q, stack_empty, stack_full;
  logic                  is_sw_reset, is_retirq, is_retlit, take, ir_retirq, ir_retlit;
  logic                  ir_ret, ret_exec, entry_ok, apb_wr, apb_setup, addr_ok;

  // The software reset is ORed in so that it reaches every register except the stack storage
  assign rst = sys_rst | soft_rst_q; // see RULE1

  // Opcode decode of the incoming word and of the held word
  assign is_sw_reset = (instr_word == RRX_OP_SW_RESET);
  assign is_retirq   = ((instr_word & RRX_RETIRQ_MASK) == RRX_OP_RETIRQ);
  assign is_retlit   = (instr_word[15:8] == RRX_OP_RETLIT_HI);
  assign take        = (state_q == RRX_IDLE) && (phase_q == RRX_Q1) && instr_valid &&
                       exec_en_q && (is_sw_reset || is_retirq || is_retlit);
  assign ir_retirq   = ((ir_q & RRX_RETIRQ_MASK) == RRX_OP_RETIRQ);
  assign ir_retlit   = (ir_q[15:8] == RRX_OP_RETLIT_HI);
  assign ir_ret      = ir_retirq || ir_retlit;
  assign ret_exec    = (state_q == RRX_EXEC) && (phase_q == RRX_Q4) && ir_ret;
  // Interrupt entry only while idle, so it never races a return
  assign entry_ok    = irq_entry && (state_q == RRX_IDLE) && !take;

  // Stack top; an empty stack reads as zero and pops do not wrap
  assign stack_empty     = (sp_q == '0);
  assign stack_full      = (sp_q == PTR_W'(STACK_DEPTH));
  assign stack_top_entry = stack_empty ? '0 : stack_q[sp_q - PTR_W'(1)];

  // Free-running phase counter, Q1 to Q4
  always_ff @(posedge clk) begin
    phase_q <= rst ? RRX_Q1 : phase_q + 2'h1;
  end

  // Sequencer: decode at Q1, act through Q4, then one no-op cycle for returns
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= RRX_IDLE;
      ir_q    <= 16'h0000;
      busy_q  <= 1'b0;
    end else begin
      unique case (state_q)
        RRX_IDLE: begin
          if (take) begin
            state_q <= RRX_EXEC;
            ir_q    <= instr_word;
            busy_q  <= 1'b1; // Busy follows the next state, so the pin is a flop
          end
        end
        RRX_EXEC: begin
          if (phase_q == RRX_Q4) begin
            state_q <= ir_ret ? RRX_FLUSH : RRX_IDLE;
            busy_q  <= ir_ret;
          end
        end
        RRX_FLUSH: begin
          if (flush_cnt_q == 3'h1) begin
            state_q <= RRX_IDLE;
            busy_q  <= 1'b0;
          end
        end
        default: begin
          state_q <= RRX_IDLE;
        end
      endcase
    end
  end

  // Software reset is decoded at Q2 and pulses one clk wide during Q3, clearing the block with it
  always_ff @(posedge clk) begin
    soft_rst_q <= !sys_rst && (state_q == RRX_EXEC) && (phase_q == RRX_Q2) &&
                  (ir_q == RRX_OP_SW_RESET) && !soft_rst_q; // see RULE1
  end

  // Second cycle of a return is a no-op that kills the prefetched word
  always_ff @(posedge clk) begin
    if (rst) begin
      flush_cnt_q <= 3'h0;
      flush_q     <= 1'b0;
    end else if (ret_exec) begin
      flush_cnt_q <= RRX_FLUSH_CLKS; // see RULE9
      flush_q     <= 1'b1;
    end else if (flush_cnt_q != 3'h0) begin
      flush_cnt_q <= flush_cnt_q - 3'h1;
      flush_q     <= (flush_cnt_q != 3'h1);
    end
  end

  // Return stack: pop at Q4 of a return, push on interrupt entry
  always_ff @(posedge clk) begin
    if (rst) begin
      sp_q <= '0;
    end else if (ret_exec && !stack_empty) begin
      sp_q <= sp_q - PTR_W'(1); // see RULE10
    end else if (entry_ok && !stack_full) begin
      sp_q <= sp_q + PTR_W'(1);
    end
  end

  // Stack storage has no reset; entries above the pointer are never read
  always_ff @(posedge clk) begin
    if (entry_ok && !stack_full) begin
      stack_q[sp_q] <= irq_ret_addr;
    end
  end

  // PC load from the stack top, latches deliberately left out
  always_ff @(posedge clk) begin
    pc_load_q <= !rst && ret_exec;
    if (rst) begin
      pc_q <= '0;
    end else if (ret_exec) begin
      pc_q <= stack_top_entry; // see RULE2 see RULE7 see RULE8
    end
  end

  // Accumulator, flags and bank select
  always_ff @(posedge clk) begin
    if (rst) begin
      acc_q    <= 8'h00;
      status_q <= 8'h00;
      bsr_q    <= 4'h0;
    end else if (ret_exec && ir_retlit) begin
      acc_q <= ir_q[7:0]; // see RULE6
    end else if (ret_exec && ir_q[RRX_SEL_BIT]) begin
      acc_q    <= acc_shadow_q; // see RULE4
      status_q <= flag_shadow_q;
      bsr_q    <= bank_shadow_q;
    end
    // Select bit clear leaves all three alone, see RULE5
  end

  // Shadow copies are taken on interrupt entry and may be set over APB
  always_ff @(posedge clk) begin
    if (rst) begin
      acc_shadow_q  <= 8'h00;
      flag_shadow_q <= 8'h00;
      bank_shadow_q <= 4'h0;
    end else if (entry_ok) begin
      acc_shadow_q  <= acc_q;
      flag_shadow_q <= status_q;
      bank_shadow_q <= bsr_q;
    end else if (apb_wr && paddr == RRX_A_SHADOW) begin
      acc_shadow_q  <= pwdata[7:0];
      flag_shadow_q <= pwdata[RRX_CORE_STAT +: 8];
      bank_shadow_q <= pwdata[RRX_CORE_BANK +: 4];
    end
  end

  // Global enables: entry clears the level taken, return-from-irq sets it again
  always_ff @(posedge clk) begin
    if (rst) begin
      high_prio_global_irq_en_q <= 1'b0;
      low_prio_global_irq_en_q <= 1'b0;
    end else if (ret_exec && ir_retirq) begin
      high_prio_global_irq_en_q <= high_prio_global_irq_en_q | irq_level_high;  // see RULE3
      low_prio_global_irq_en_q <= low_prio_global_irq_en_q | !irq_level_high; // see RULE3
    end else if (entry_ok) begin
      high_prio_global_irq_en_q <= high_prio_global_irq_en_q & !irq_level_high;
      low_prio_global_irq_en_q <= low_prio_global_irq_en_q & irq_level_high;
    end else if (apb_wr && paddr == RRX_A_CORE) begin
      high_prio_global_irq_en_q <= pwdata[RRX_CORE_HIGH_PRIO_GLOBAL_IRQ_EN];
      low_prio_global_irq_en_q <= pwdata[RRX_CORE_LOW_PRIO_GLOBAL_IRQ_EN];
    end
  end

  // APB: zero-wait slave, ready in every access phase
  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pwrite && pready;
  assign addr_ok   = (paddr == RRX_A_CTRL) || (paddr == RRX_A_CORE) ||
                     (paddr == RRX_A_PC) || (paddr == RRX_A_STACK) ||
                     (paddr == RRX_A_LATCH) || (paddr == RRX_A_SHADOW);

  // Read data is sampled at setup so it stands through the access phase
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (paddr == RRX_A_CTRL) begin
      rd_mux[RRX_CTRL_EN] = exec_en_q;
    end else if (paddr == RRX_A_CORE) begin
      rd_mux[7:0]                  = acc_q;
      rd_mux[RRX_CORE_STAT +: 8]   = status_q;
      rd_mux[RRX_CORE_BANK +: 4]   = bsr_q;
      rd_mux[RRX_CORE_LOW_PRIO_GLOBAL_IRQ_EN]        = low_prio_global_irq_en_q;
      rd_mux[RRX_CORE_HIGH_PRIO_GLOBAL_IRQ_EN]        = high_prio_global_irq_en_q;
      rd_mux[RRX_CORE_ACT]         = (state_q != RRX_IDLE);
    end else if (paddr == RRX_A_PC) begin
      rd_mux[PC_W-1:0] = pc_q;
    end else if (paddr == RRX_A_STACK) begin
      rd_mux[PTR_W-1:0]    = sp_q;
      rd_mux[RRX_STK_FULL] = stack_full;
    end else if (paddr == RRX_A_LATCH) begin
      rd_mux[7:0]                = pc_latch_high_q;
      rd_mux[RRX_LATCH_UP +: 8]  = pc_latch_upper_q;
    end else if (paddr == RRX_A_SHADOW) begin
      rd_mux[7:0]                = acc_shadow_q;
      rd_mux[RRX_CORE_STAT +: 8] = flag_shadow_q;
      rd_mux[RRX_CORE_BANK +: 4] = bank_shadow_q;
    end
  end

  // Bus answer registers
  always_ff @(posedge clk) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= apb_setup;
      pslverr <= apb_setup && !addr_ok;
      if (apb_setup) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  // Control and PC latch registers; only software writes them
  always_ff @(posedge clk) begin
    if (rst) begin
      exec_en_q        <= RRX_CTRL_RST[RRX_CTRL_EN];
      pc_latch_high_q  <= 8'h00;
      pc_latch_upper_q <= 8'h00;
    end else if (apb_wr) begin
      if (paddr == RRX_A_CTRL) begin
        exec_en_q <= pwdata[RRX_CTRL_EN];
      end
      if (paddr == RRX_A_LATCH) begin
        pc_latch_high_q  <= pwdata[7:0];
        pc_latch_upper_q <= pwdata[RRX_LATCH_UP +: 8];
      end
    end
  end

  // Core outputs straight from their flip-flops
  assign pc_o                      = pc_q;
  assign pc_load_o                 = pc_load_q;
  assign flush_o                   = flush_q;
  assign core_reset_o              = soft_rst_q;
  assign busy_o                    = busy_q;
  assign accumulator_o             = acc_q;
  assign status_o                  = status_q;
  assign bank_select_reg_o         = bsr_q;
  assign high_prio_global_irq_en_o = high_prio_global_irq_en_q;
  assign low_prio_global_irq_en_o  = low_prio_global_irq_en_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_soft_reset_start: assert property ( // see RULE1
    take && is_sw_reset |-> ##2 soft_rst_q ##1 (acc_q == 8'h00 && !high_prio_global_irq_en_q && sp_q == '0))
    else $error("software reset did not clear the core");
  chk_pop_to_pc: assert property ( // see RULE2
    take && (is_retirq || is_retlit) ##3 1'b1 |=> pc_load_q && pc_q == $past(stack_top_entry))
    else $error("return did not load the popped entry into the PC");
  chk_enable_set: assert property ( // see RULE3
    ret_exec && ir_retirq |=> ($past(irq_level_high) ? high_prio_global_irq_en_q && $stable(low_prio_global_irq_en_q) :
      low_prio_global_irq_en_q && $stable(high_prio_global_irq_en_q)) && (ir_q[RRX_SEL_BIT] || $stable(status_q)))
    else $error("return from irq did not set the right global enable");
  chk_shadow_restore: assert property ( // see RULE4
    ret_exec && ir_retirq && ir_q[RRX_SEL_BIT] |=>
      acc_q == $past(acc_shadow_q) && status_q == $past(flag_shadow_q) &&
      bsr_q == $past(bank_shadow_q))
    else $error("shadow copies not restored");
  chk_shadow_skip: assert property ( // see RULE5
    ret_exec && ir_retirq && !ir_q[RRX_SEL_BIT] |=>
      $stable(acc_q) && $stable(status_q) && $stable(bsr_q))
    else $error("registers changed with select bit clear");
  chk_literal_load: assert property ( // see RULE6
    take && is_retlit ##3 1'b1 |=> acc_q == $past(instr_word[7:0], 4) && $stable(status_q))
    else $error("literal not placed in accumulator");
  chk_two_cycles: assert property ( // see RULE7
    take && is_retlit |-> ##4 pc_load_q && busy_o ##1 (flush_q && busy_o)[*3] ##1
      !flush_q && !busy_o)
    else $error("return literal did not take two cycles");
  chk_latch_hold: assert property ( // see RULE8
    ret_exec && !apb_wr |=> $stable(pc_latch_high_q) && $stable(pc_latch_upper_q))
    else $error("return changed a PC latch register");
  chk_flush_cycle: assert property ( // see RULE9
    ret_exec |=> flush_q[*4] ##1 !flush_q)
    else $error("no-op cycle after return is not four clocks");
  chk_stack_pop: assert property ( // see RULE10
    ret_exec && !stack_empty |=> sp_q == $past(sp_q) - PTR_W'(1))
    else $error("pop did not move the stack pointer back by one");

endmodule
`default_nettype wire

// *** verification/tb_rrx_exec.sv ***
/*
  Self-checking bench for rrx_exec: drives the instruction, interrupt
  entry and APB ports directly and checks returns and software reset.
  Assumes rrx_pkg and rrx_exec are compiled before this file.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_rrx_exec;
  import rrx_pkg::*;

  typedef struct packed {
    logic [20:0] pc;
    logic [7:0]  acc;
    logic [7:0]  st;
    logic [3:0]  bk;
  } rrx_note_s;

  logic        clk;
  logic        sys_rst;
  logic        instr_valid;
  logic [15:0] instr_word;
  logic        irq_entry;
  logic        irq_level_high;
  logic [20:0] irq_ret_addr;
  logic [20:0] pc_o;
  logic        pc_load_o;
  logic        flush_o;
  logic        core_reset_o;
  logic        busy_o;
  logic [7:0]  accumulator_o;
  logic [7:0]  status_o;
  logic [3:0]  bank_select_reg_o;
  logic        hi_en;
  logic        lo_en;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  int          err_count;
  int          compares;
  int          ph = 0;
  rrx_note_s   notes[$];
  rrx_note_s   nt;
  logic [31:0] rd;
  logic        er;
  logic [20:0] a1;
  logic [20:0] a2;
  logic [7:0]  k;
  logic [19:0] sh;
  logic [15:0] lt;
  logic [7:0]  fm;
  logic [7:0]  bm;
  logic [7:0]  lm;
  logic [7:0]  rm;

  rrx_exec dut (
    .clk(clk), .sys_rst(sys_rst), .instr_valid(instr_valid), .instr_word(instr_word),
    .irq_entry(irq_entry), .irq_level_high(irq_level_high), .irq_ret_addr(irq_ret_addr),
    .pc_o(pc_o), .pc_load_o(pc_load_o), .flush_o(flush_o), .core_reset_o(core_reset_o),
    .busy_o(busy_o), .accumulator_o(accumulator_o), .status_o(status_o),
    .bank_select_reg_o(bank_select_reg_o), .high_prio_global_irq_en_o(hi_en),
    .low_prio_global_irq_en_o(lo_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
  );

  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Mirror of the phase counter: either reset restarts it at Q1
  always @(posedge clk) begin
    ph <= (sys_rst || core_reset_o) ? 0 : ph + 1;
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Each program counter load consumes the oldest expected note
  always @(negedge clk) begin
    if (pc_load_o === 1'b1) begin
      if (notes.size() == 0) begin
        chk(32'h1, 32'h0);
      end else begin
        nt = notes.pop_front();
        chk(pc_o, nt.pc);
        chk(accumulator_o, nt.acc);
        chk(status_o, nt.st);
        chk(bank_select_reg_o, nt.bk);
      end
    end
  end

  // One APB transfer; waits for pready, only the watchdog ends a hang
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rdchk(input logic [7:0] a, input logic [31:0] exp, input logic eerr);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
    chk(er, eerr);
  endtask

  task irq(input logic [20:0] a, input logic lvl);
    @(posedge clk);
    irq_entry <= 1'b1;
    irq_ret_addr <= a;
    irq_level_high <= lvl;
    @(posedge clk);
    irq_entry <= 1'b0;
    @(posedge clk);
    @(negedge clk);
  endtask

  task watch();
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      fm[i] = flush_o;
      bm[i] = busy_o;
      lm[i] = pc_load_o;
      rm[i] = core_reset_o;
    end
  endtask

  // Offer a word at the next idle Q1 edge; returns keep offering a
  // return-literal while busy, which must be ignored
  task exec(input logic [15:0] w);
    int n;
    logic rst;
    rst = (w === RRX_OP_SW_RESET);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((busy_o !== 1'b0 || ph % 4 != 3) && n < 64);
    instr_valid <= 1'b1;
    instr_word <= w;
    @(posedge clk);
    instr_word <= {RRX_OP_RETLIT_HI, 8'($urandom())};
    instr_valid <= !rst;
    fork
      watch();
      begin
        repeat (5) @(posedge clk);
        instr_valid <= 1'b0;
      end
    join
    chk(lm, rst ? 8'h00 : 8'h08);
    chk(fm, rst ? 8'h00 : 8'h78);
    chk(bm, rst ? 8'h03 : 8'h7F);
    chk(rm, rst ? 8'h02 : 8'h00);
  endtask

  task wrap_up();
    $display("checks %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Whole run needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    wrap_up();
  end

  initial begin
    {instr_valid, irq_entry, irq_level_high, psel, penable, pwrite} = 6'h00;
    {instr_word, irq_ret_addr, paddr, pwdata} = 77'h0;
    sys_rst = 1'b1;
    err_count = 0;
    compares = 0;
    void'($urandom(32'hBF54A337));
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    rdchk(RRX_A_CTRL, RRX_CTRL_RST, 1'b0);
    rdchk(RRX_A_CORE, 32'h0, 1'b0);
    rdchk(8'h40, 32'h0, 1'b1);
    $display("test reset and map done");
    apb(1'b1, RRX_A_CORE, 32'h0300_0000);
    a1 = 21'($urandom());
    a2 = 21'($urandom());
    irq(a1, 1'b1);
    chk(hi_en, 1'b0);
    irq(a2, 1'b0);
    chk(lo_en, 1'b0);
    rdchk(RRX_A_STACK, 32'h2, 1'b0);
    $display("test interrupt entry done");
    sh = 20'($urandom());
    lt = 16'($urandom());
    apb(1'b1, RRX_A_SHADOW, {12'h0, sh});
    apb(1'b1, RRX_A_LATCH, {16'h0, lt});
    irq_level_high <= 1'b0;
    notes.push_back('{a2, sh[7:0], sh[15:8], sh[19:16]});
    exec(RRX_OP_RETIRQ | 16'h0001);
    chk(lo_en, 1'b1);
    chk(hi_en, 1'b0);
    rdchk(RRX_A_STACK, 32'h1, 1'b0);
    rdchk(RRX_A_LATCH, {16'h0, lt}, 1'b0);
    $display("test restoring return done");
    k = 8'($urandom());
    irq_level_high <= 1'b1;
    notes.push_back('{a1, k, sh[15:8], sh[19:16]});
    exec({RRX_OP_RETLIT_HI, k});
    chk(hi_en, 1'b0);
    rdchk(RRX_A_STACK, 32'h0, 1'b0);
    rdchk(RRX_A_LATCH, {16'h0, lt}, 1'b0);
    $display("test literal return done");
    notes.push_back('{21'h0, k, sh[15:8], sh[19:16]});
    exec(RRX_OP_RETIRQ);
    chk(hi_en, 1'b1);
    chk(lo_en, 1'b1);
    $display("test plain return done");
    // With execution disabled an offered return must be ignored
    apb(1'b1, RRX_A_CTRL, 32'h0000_0000);
    instr_word <= {RRX_OP_RETLIT_HI, 8'($urandom())};
    instr_valid <= 1'b1;
    repeat (8) @(posedge clk);
    instr_valid <= 1'b0;
    @(negedge clk);
    chk(busy_o, 1'b0);
    chk(accumulator_o, k);
    rdchk(RRX_A_STACK, 32'h0, 1'b0);
    rdchk(RRX_A_CTRL, 32'h0, 1'b0);
    apb(1'b1, RRX_A_CTRL, 32'h0000_0001);
    $display("test disabled core done");
    exec(RRX_OP_SW_RESET);
    rdchk(RRX_A_CTRL, RRX_CTRL_RST, 1'b0);
    rdchk(RRX_A_CORE, 32'h0, 1'b0);
    rdchk(RRX_A_SHADOW, 32'h0, 1'b0);
    rdchk(RRX_A_LATCH, 32'h0, 1'b0);
    chk(notes.size(), 0);
    $display("test software reset done");
    wrap_up();
  end
endmodule
`default_nettype wire
